// file: rtl/speed_comp_defs.svh
// constants for the analog speed command compensation datapath
//
// Functional notes
// - codes 0-3,6,7,10-13,16,17 add auxiliary input
// - codes 4,5,14,15 select override mode
// - negative sum: clamp, or reverse if polarity
// - auxiliary also adds to multispeed or secondary
// - primary plus auxiliary times primary ratio/100
// - secondary plus auxiliary times secondary ratio/100
// - ratios 0-100%, reset 100% and 75%
// - override ignored without main speed present
// - override bias 50%, gain 150%, 0-200%
// - override frequency is main times percent/100
// - multispeed compensation only when select is 1
// - first-order filter, setting 0-8, reset 1
// - filter settings span about 5ms to 1.3s
// - gain frequencies 0-400Hz, reset 60Hz
// - bias frequencies 0-400Hz, reset 0Hz
// - points 0-300%, resets 0,100,20,100 percent
// - display unit writable always, reset percent
// - settings writable only when group select 0
// - codes 6,7,16,17 current; some codes 10V
`ifndef SPEED_COMP_DEFS_SVH
`define SPEED_COMP_DEFS_SVH
// percentages in 0.1% units, frequencies in 0.01Hz units
`define RST_SEL_CODE 5'h01
`define RST_PRI_RATIO 11'h3e8
`define RST_SEC_RATIO 11'h2ee
`define RST_OVR_BIAS 12'h1f4
`define RST_OVR_GAIN 12'h5dc
`define RST_FILTER 4'h1
`define RST_GAIN_FREQ 16'h1770
`define RST_BIAS_FREQ 16'h0000
`define RST_PRI_BIAS_PT 12'h000
`define RST_PRI_GAIN_PT 12'h3e8
`define RST_SEC_BIAS_PT 12'h0c8
`define RST_SEC_GAIN_PT 12'h3e8
`define MAX_RATIO 11'h3e8
`define MAX_OVR 12'h7d0
`define MAX_FREQ 16'h9c40
`define MAX_POINT 12'hbb8
`define MAX_FILTER 4'h8
`define PCT_FULL 12'h3e8
// filter tick: 5 ms base at 50 MHz, shift per setting step
`define CLK_MHZ 50
`define FILTER_BASE_US 5000
`define FILTER_BASE_CYC ((`FILTER_BASE_US * `CLK_MHZ) / 16)
`define FILTER_SHIFT 4
`endif

// file: rtl/speed_comp_pkg.sv
// types for the analog speed command compensation datapath
package speed_comp_pkg;
    typedef enum logic [1:0] {
        MODE_ADD_CLAMP = 2'b00,
        MODE_ADD_REV = 2'b01,
        MODE_OVERRIDE = 2'b10
    } comp_mode_t;

    typedef struct packed {
        logic [4:0] sel_code;
        logic [10:0] pri_ratio;
        logic [10:0] sec_ratio;
        logic [11:0] ovr_bias;
        logic [11:0] ovr_gain;
        logic [3:0] filter_set;
        logic multi_comp;
        logic disp_unit;
        logic [15:0] pri_gain_freq;
        logic [15:0] sec_gain_freq;
        logic [15:0] pri_bias_freq;
        logic [15:0] sec_bias_freq;
        logic [11:0] pri_bias_pt;
        logic [11:0] pri_gain_pt;
        logic [11:0] sec_bias_pt;
        logic [11:0] sec_gain_pt;
        logic [15:0] tick_cnt;
        logic [15:0] sub_cnt;
        logic signed [17:0] flt_aux;
        logic signed [17:0] flt_pri;
        logic signed [17:0] flt_sec;
        logic [15:0] freq;
        logic reverse;
        logic pri_current;
        logic pri_10v;
    } comp_state_t;
endpackage

// file: rtl/speed_comp.sv
// analog speed command compensation: filters, bias/gain, added and override compensation
`timescale 1ns/100ps
`include "speed_comp_defs.svh"
module speed_comp
    import speed_comp_pkg::*;
(
    input wire logic clock, // 50 MHz system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic signed [11:0] aux_in, // auxiliary terminal, signed 0.1% units
    input wire logic [11:0] pri_in, // primary terminal, 0.1% units
    input wire logic [11:0] sec_in, // secondary terminal, 0.1% units
    input wire logic secondary_input_enable, // secondary terminal valid
    input wire logic forward_start, // forward start command
    input wire logic multispeed_active, // multispeed or remote setting in use
    input wire logic [15:0] multispeed_freq, // multispeed frequency, 0.01 Hz
    input wire logic [4:0] user_group_read_select, // must be 0 to write settings other than the display unit
    input wire logic wr_en, // one-cycle setting write strobe
    input wire logic [4:0] wr_sel, // which setting to write
    input wire logic [15:0] wr_data, // setting value
    output logic wr_ack, // write accepted
    output logic wr_err, // write refused or out of range
    output logic [15:0] freq_cmd, // frequency command, 0.01 Hz
    output logic reverse_cmd, // reverse rotation request
    output logic primary_current_mode, // primary terminal as current input
    output logic primary_10v_range, // primary terminal 0 to 10 V range
    output logic display_unit_select, // 0 percent, 1 volts or milliamps
    output logic [15:0] setting_rd // value of setting wr_sel
);
    localparam logic [4:0] S_SEL = 5'h00, S_PRAT = 5'h01, S_SRAT = 5'h02, S_OB = 5'h03;
    localparam logic [4:0] S_OG = 5'h04, S_FLT = 5'h05, S_MC = 5'h06, S_DU = 5'h07;
    localparam logic [4:0] S_PGF = 5'h08, S_SGF = 5'h09, S_PBF = 5'h0a, S_SBF = 5'h0b;
    localparam logic [4:0] S_PBP = 5'h0c, S_PGP = 5'h0d, S_SBP = 5'h0e, S_SGP = 5'h0f;

    comp_state_t q, d;
    logic sec_s1, sec_s2, sec_s3, fwd_s1, fwd_s2, fwd_s3;
    logic sec_ok_q, fwd_ok_q;

    // ==========================================================
    // helpers
    function automatic logic valid_code(input logic [4:0] c);
        valid_code = (c <= 5'd7) || (c >= 5'd10 && c <= 5'd17);
    endfunction

    function automatic comp_mode_t mode_of(input logic [4:0] c);
        if (c == 5'd4 || c == 5'd5 || c == 5'd14 || c == 5'd15) begin
            mode_of = MODE_OVERRIDE;
        end else if (c >= 5'd10) begin
            mode_of = MODE_ADD_REV;
        end else begin
            mode_of = MODE_ADD_CLAMP;
        end
    endfunction

    // a*b/1000 with a signed and b unsigned percent
    function automatic logic signed [31:0] pct_mul(input logic signed [31:0] a,
                                                   input logic [11:0] b);
        pct_mul = (a * $signed({20'h0, b})) / 32'sd1000;
    endfunction

    // linear map through (bias_pt,bias_f) and (gain_pt,gain_f)
    function automatic logic signed [31:0] lin_map(input logic signed [31:0] x,
        input logic [11:0] bp, input logic [11:0] gp,
        input logic [15:0] bf, input logic [15:0] gf);
        logic signed [31:0] span;
        span = $signed({20'h0, gp}) - $signed({20'h0, bp});
        if (span == 32'sd0) begin
            lin_map = $signed({16'h0, bf});
        end else begin
            lin_map = $signed({16'h0, bf}) + ((x - $signed({20'h0, bp}))
                * ($signed({16'h0, gf}) - $signed({16'h0, bf}))) / span;
        end
    endfunction

    // one step of the first-order filter: y += (x - y)/16
    function automatic logic signed [17:0] lpf(input logic signed [17:0] y,
                                               input logic signed [11:0] x);
        logic signed [17:0] xe;
        xe = {x, 6'h00};
        lpf = y + ((xe - y) >>> `FILTER_SHIFT);
    endfunction

    function automatic logic [15:0] clamp_freq(input logic signed [31:0] f);
        if (f < 32'sd0) begin
            clamp_freq = 16'h0000;
        end else if (f > $signed({16'h0, `MAX_FREQ})) begin
            clamp_freq = `MAX_FREQ;
        end else begin
            clamp_freq = f[15:0];
        end
    endfunction

    // ==========================================================
    // pin synchronisers; a change counts when stages 2 and 3 agree
    always_ff @(posedge clock) begin
        if (srst) begin
            {sec_s1, sec_s2, sec_s3, fwd_s1, fwd_s2, fwd_s3} <= 6'h00;
            sec_ok_q <= 1'b0;
            fwd_ok_q <= 1'b0;
        end else begin
            sec_s1 <= secondary_input_enable;
            sec_s2 <= sec_s1;
            sec_s3 <= sec_s2;
            fwd_s1 <= forward_start;
            fwd_s2 <= fwd_s1;
            fwd_s3 <= fwd_s2;
            if (sec_s2 == sec_s3) begin
                sec_ok_q <= sec_s3;
            end
            if (fwd_s2 == fwd_s3) begin
                fwd_ok_q <= fwd_s3;
            end
        end
    end

    // ==========================================================
    // settings, filters and datapath
    logic wr_ok, in_range;
    logic [15:0] tick_len;
    logic signed [31:0] aux_f, pri_f, sec_f, pri_hz, sec_hz, main_hz, sum_hz, ovr_pct;
    logic signed [11:0] pri_x, sec_x;
    comp_mode_t mode;

    always_comb begin
        d = q;
        // writes gated by user group select, except the display unit
        wr_ok = (wr_sel == S_DU) || (user_group_read_select == 5'h00);
        case (wr_sel)
            S_SEL: in_range = valid_code(wr_data[4:0]) && wr_data[15:5] == 11'h0;
            S_PRAT, S_SRAT: in_range = wr_data <= {5'h0, `MAX_RATIO};
            S_OB, S_OG: in_range = wr_data <= {4'h0, `MAX_OVR};
            S_FLT: in_range = wr_data <= {12'h0, `MAX_FILTER};
            S_MC, S_DU: in_range = wr_data <= 16'h0001;
            S_PGF, S_SGF, S_PBF, S_SBF: in_range = wr_data <= `MAX_FREQ;
            S_PBP, S_PGP, S_SBP, S_SGP: in_range = wr_data <= {4'h0, `MAX_POINT};
            default: in_range = 1'b0;
        endcase
        if (wr_en && wr_ok && in_range) begin
            case (wr_sel)
                S_SEL: d.sel_code = wr_data[4:0];
                S_PRAT: d.pri_ratio = wr_data[10:0];
                S_SRAT: d.sec_ratio = wr_data[10:0];
                S_OB: d.ovr_bias = wr_data[11:0];
                S_OG: d.ovr_gain = wr_data[11:0];
                S_FLT: d.filter_set = wr_data[3:0];
                S_MC: d.multi_comp = wr_data[0];
                S_DU: d.disp_unit = wr_data[0];
                S_PGF: d.pri_gain_freq = wr_data;
                S_SGF: d.sec_gain_freq = wr_data;
                S_PBF: d.pri_bias_freq = wr_data;
                S_SBF: d.sec_bias_freq = wr_data;
                S_PBP: d.pri_bias_pt = wr_data[11:0];
                S_PGP: d.pri_gain_pt = wr_data[11:0];
                S_SBP: d.sec_bias_pt = wr_data[11:0];
                S_SGP: d.sec_gain_pt = wr_data[11:0];
                default: d.sel_code = q.sel_code;
            endcase
        end

        // filter rate: tick = base/16, sub-period doubles per setting step;
        // 16 filter steps per time constant gives about 5 ms at 0 and 1.3 s at 8
        tick_len = 16'(`FILTER_BASE_CYC);
        d.tick_cnt = q.tick_cnt + 16'h0001;
        if (q.tick_cnt >= tick_len - 16'h0001) begin
            d.tick_cnt = 16'h0000;
            d.sub_cnt = q.sub_cnt + 16'h0001;
            if (q.sub_cnt >= (16'h0001 << q.filter_set) - 16'h0001) begin
                d.sub_cnt = 16'h0000;
                d.flt_aux = lpf(q.flt_aux, aux_in);
                d.flt_pri = lpf(q.flt_pri, $signed(pri_in));
                d.flt_sec = lpf(q.flt_sec, $signed(sec_in));
            end
        end

        mode = mode_of(q.sel_code);
        d.pri_current = (q.sel_code == 5'd6) || (q.sel_code == 5'd7)
            || (q.sel_code == 5'd16) || (q.sel_code == 5'd17);
        d.pri_10v = (q.sel_code == 5'd0) || (q.sel_code == 5'd2) || (q.sel_code == 5'd4)
            || (q.sel_code == 5'd10) || (q.sel_code == 5'd12) || (q.sel_code == 5'd14);

        aux_f = 32'(q.flt_aux >>> 6);
        pri_f = 32'(q.flt_pri >>> 6);
        sec_f = 32'(q.flt_sec >>> 6);
        pri_x = 12'(pri_f);
        sec_x = 12'(sec_f);
        pri_hz = 32'sd0;
        sec_hz = 32'sd0;
        main_hz = 32'sd0;
        sum_hz = 32'sd0;
        ovr_pct = 32'sd0;
        d.reverse = 1'b0;
        if (mode == MODE_OVERRIDE) begin
            // main speed from multispeed, secondary or auxiliary, override from primary
            if (multispeed_active && q.multi_comp) begin
                main_hz = $signed({16'h0, multispeed_freq});
            end else if (sec_ok_q) begin
                main_hz = lin_map(sec_f, q.sec_bias_pt, q.sec_gain_pt,
                    q.sec_bias_freq, q.sec_gain_freq);
            end else if (aux_f > 32'sd0) begin
                main_hz = lin_map(aux_f, q.pri_bias_pt, q.pri_gain_pt,
                    q.pri_bias_freq, q.pri_gain_freq);
            end
            ovr_pct = $signed({20'h0, q.ovr_bias}) + pct_mul(32'(pri_x),
                12'(q.ovr_gain - q.ovr_bias));
            if (main_hz <= 32'sd0) begin
                sum_hz = 32'sd0;
            end else begin
                sum_hz = pct_mul(main_hz, 12'(ovr_pct));
            end
        end else begin
            if (multispeed_active) begin
                sum_hz = $signed({16'h0, multispeed_freq});
                if (q.multi_comp) begin
                    sum_hz = sum_hz + pct_mul(lin_map(aux_f, 12'h000, q.pri_gain_pt,
                        16'h0000, q.pri_gain_freq), {1'b0, q.pri_ratio});
                end
            end else if (sec_ok_q) begin
                sec_hz = 32'(sec_x) + pct_mul(aux_f, {1'b0, q.sec_ratio});
                sum_hz = lin_map(sec_hz, q.sec_bias_pt, q.sec_gain_pt,
                    q.sec_bias_freq, q.sec_gain_freq);
            end else begin
                pri_hz = 32'(pri_x) + pct_mul(aux_f, {1'b0, q.pri_ratio});
                sum_hz = lin_map(pri_hz, q.pri_bias_pt, q.pri_gain_pt,
                    q.pri_bias_freq, q.pri_gain_freq);
            end
            if (sum_hz < 32'sd0) begin
                if (mode == MODE_ADD_REV && fwd_ok_q) begin
                    d.reverse = 1'b1;
                    sum_hz = -sum_hz;
                end else begin
                    sum_hz = 32'sd0;
                end
            end
        end
        d.freq = clamp_freq(sum_hz);

        if (srst) begin
            d = '0;
            d.sel_code = `RST_SEL_CODE;
            d.pri_ratio = `RST_PRI_RATIO;
            d.sec_ratio = `RST_SEC_RATIO;
            d.ovr_bias = `RST_OVR_BIAS;
            d.ovr_gain = `RST_OVR_GAIN;
            d.filter_set = `RST_FILTER;
            d.pri_gain_freq = `RST_GAIN_FREQ;
            d.sec_gain_freq = `RST_GAIN_FREQ;
            d.pri_bias_freq = `RST_BIAS_FREQ;
            d.sec_bias_freq = `RST_BIAS_FREQ;
            d.pri_bias_pt = `RST_PRI_BIAS_PT;
            d.pri_gain_pt = `RST_PRI_GAIN_PT;
            d.sec_bias_pt = `RST_SEC_BIAS_PT;
            d.sec_gain_pt = `RST_SEC_GAIN_PT;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    // ==========================================================
    // outputs
    always_comb begin
        wr_ack = wr_en && wr_ok && in_range;
        wr_err = wr_en && !(wr_ok && in_range);
        case (wr_sel)
            S_SEL: setting_rd = {11'h0, q.sel_code};
            S_PRAT: setting_rd = {5'h0, q.pri_ratio};
            S_SRAT: setting_rd = {5'h0, q.sec_ratio};
            S_OB: setting_rd = {4'h0, q.ovr_bias};
            S_OG: setting_rd = {4'h0, q.ovr_gain};
            S_FLT: setting_rd = {12'h0, q.filter_set};
            S_MC: setting_rd = {15'h0, q.multi_comp};
            S_DU: setting_rd = {15'h0, q.disp_unit};
            S_PGF: setting_rd = q.pri_gain_freq;
            S_SGF: setting_rd = q.sec_gain_freq;
            S_PBF: setting_rd = q.pri_bias_freq;
            S_SBF: setting_rd = q.sec_bias_freq;
            S_PBP: setting_rd = {4'h0, q.pri_bias_pt};
            S_PGP: setting_rd = {4'h0, q.pri_gain_pt};
            S_SBP: setting_rd = {4'h0, q.sec_bias_pt};
            S_SGP: setting_rd = {4'h0, q.sec_gain_pt};
            default: setting_rd = 16'h0000;
        endcase
    end

    assign freq_cmd = q.freq;
    assign reverse_cmd = q.reverse;
    assign primary_current_mode = q.pri_current;
    assign primary_10v_range = q.pri_10v;
    assign display_unit_select = q.disp_unit;
endmodule

// file: tb/speed_comp_asserts.sv
// assertion checker for the speed command compensation block
`timescale 1ns/100ps
module speed_comp_asserts (
    input wire logic clock, // system clock
    input wire logic srst, // sync reset
    input wire logic [4:0] user_group_read_select, // write gate
    input wire logic wr_en, // write strobe
    input wire logic [4:0] wr_sel, // setting index
    input wire logic [15:0] wr_data, // setting value
    input wire logic wr_ack, // accepted
    input wire logic wr_err, // refused
    input wire logic [15:0] freq_cmd, // frequency command
    input wire logic reverse_cmd, // reverse request
    input wire logic primary_current_mode, // current decode
    input wire logic display_unit_select // unit select
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ==========================================
    // write acceptance
    AST_GROUP_GATE: assert property (wr_en && user_group_read_select != 5'h00 &&
        wr_sel != 5'h07 |-> wr_err && !wr_ack) else $error("gated write accepted");
    AST_ACK_CAUSE: assert property (wr_ack |-> wr_en && !wr_err)
        else $error("ack without a clean write");
    AST_DISP_WRITE: assert property (wr_en && wr_sel == 5'h07 && wr_data[15:1] == 15'h0000
        |-> wr_ack ##1 display_unit_select == $past(wr_data[0])) else $error("unit write lost");
    AST_RATIO_RANGE: assert property (wr_en && wr_sel inside {5'h01, 5'h02} &&
        wr_data > 16'h03e8 |-> wr_err) else $error("ratio over range taken");
    AST_OVR_RANGE: assert property (wr_en && wr_sel inside {5'h03, 5'h04} &&
        wr_data > 16'h07d0 |-> wr_err) else $error("override over range taken");
    AST_FILTER_RANGE: assert property (wr_en && wr_sel == 5'h05 && wr_data > 16'h0008
        |-> wr_err) else $error("filter over range taken");
    AST_FREQ_RANGE: assert property (wr_en && wr_sel inside {[5'h08:5'h0b]} &&
        wr_data > 16'h9c40 |-> wr_err) else $error("frequency over range taken");
    AST_POINT_RANGE: assert property (wr_en && wr_sel inside {[5'h0c:5'h0f]} &&
        wr_data > 16'h0bb8 |-> wr_err) else $error("point over range taken");
    // ==========================================
    // outputs
    AST_RESET_OUT: assert property ($fell(srst) |-> freq_cmd == 16'h0000 &&
        !reverse_cmd && !display_unit_select) else $error("outputs not cleared by reset");
    AST_CURRENT_DECODE: assert property (wr_ack && wr_sel == 5'h00 &&
        wr_data inside {16'h0006, 16'h0007, 16'h0010, 16'h0011} |-> ##[1:3] primary_current_mode)
        else $error("current mode not decoded");
    AST_FREQ_MAX: assert property (freq_cmd <= 16'h9c40)
        else $error("frequency above ceiling");
    COV_ACK: cover property (wr_ack);
    COV_ERR: cover property (wr_err);
    COV_REV: cover property ($rose(reverse_cmd));
endmodule

bind speed_comp speed_comp_asserts speed_comp_asserts_i (.clock(clock), .srst(srst),
    .user_group_read_select(user_group_read_select), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .wr_ack(wr_ack), .wr_err(wr_err), .freq_cmd(freq_cmd),
    .reverse_cmd(reverse_cmd), .primary_current_mode(primary_current_mode),
    .display_unit_select(display_unit_select));

// file: tb/terminal_model.sv
// converter and terminal-signal model feeding the analog inputs
`timescale 1ns/100ps
module terminal_model (
    input wire logic clock, // system clock
    input wire logic signed [11:0] aux_set, // wanted auxiliary level
    input wire logic [11:0] pri_set, // wanted primary level
    input wire logic [11:0] sec_set, // wanted secondary level
    input wire logic sec_use, // secondary terminal wanted
    input wire logic fwd_set, // forward start wanted
    output logic signed [11:0] aux_in, // converted auxiliary
    output logic [11:0] pri_in, // converted primary
    output logic [11:0] sec_in, // converted secondary
    output logic secondary_input_enable, // enable pin
    output logic forward_start // start pin
);
    initial begin
        aux_in = 12'h000;
        pri_in = 12'h000;
        sec_in = 12'h000;
        secondary_input_enable = 1'b0;
        forward_start = 1'b0;
    end
    // converters update off the sampling edge
    always @(negedge clock) begin
        aux_in <= aux_set;
        pri_in <= pri_set;
        forward_start <= fwd_set;
        secondary_input_enable <= sec_use;
        // enable leads the value so the terminal is never used unenabled
        sec_in <= (secondary_input_enable && sec_use) ? sec_set : 12'h000;
    end
endmodule

// file: tb/speed_comp_tb.sv
// self-checking bench for the speed command compensation block
`timescale 1ns/100ps
module speed_comp_tb;
    import speed_comp_pkg::*;
    logic clock = 1'b0, srst = 1'b1, wr_en = 1'b0, sec_use = 1'b0, fwd_set = 1'b0;
    logic [4:0] user_group_read_select = 5'h00, wr_sel = 5'h00;
    logic [15:0] wr_data = 16'h0000;
    logic signed [11:0] aux_set = 12'h000;
    logic [11:0] pri_set = 12'h000, sec_set = 12'h000;
    logic signed [11:0] aux_in;
    logic [11:0] pri_in, sec_in;
    logic secondary_input_enable, forward_start, wr_ack, wr_err, reverse_cmd;
    logic primary_current_mode, primary_10v_range, display_unit_select, a, e, cur, ten;
    logic [15:0] freq_cmd, setting_rd, v;
    int bad_count = 0, n_compared = 0;
    localparam logic [15:0] RST_TAB [16] = '{16'h0001, 16'h03e8, 16'h02ee, 16'h01f4, 16'h05dc,
        16'h0001, 16'h0000, 16'h0000, 16'h1770, 16'h1770, 16'h0000, 16'h0000, 16'h0000,
        16'h03e8, 16'h00c8, 16'h03e8};
    localparam logic [15:0] MAX_TAB [16] = '{16'h0011, 16'h03e8, 16'h03e8, 16'h07d0, 16'h07d0,
        16'h0008, 16'h0001, 16'h0001, 16'h9c40, 16'h9c40, 16'h9c40, 16'h9c40, 16'h0bb8,
        16'h0bb8, 16'h0bb8, 16'h0bb8};
    always #10 clock = ~clock;
    speed_comp speed_comp_i (.clock(clock), .srst(srst), .aux_in(aux_in), .pri_in(pri_in),
        .sec_in(sec_in), .secondary_input_enable(secondary_input_enable),
        .forward_start(forward_start), .multispeed_active(1'b0), .multispeed_freq(16'h0000),
        .user_group_read_select(user_group_read_select), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_data(wr_data), .wr_ack(wr_ack), .wr_err(wr_err), .freq_cmd(freq_cmd),
        .reverse_cmd(reverse_cmd), .primary_current_mode(primary_current_mode),
        .primary_10v_range(primary_10v_range), .display_unit_select(display_unit_select),
        .setting_rd(setting_rd));
    terminal_model terminal_model_i (.clock(clock), .aux_set(aux_set), .pri_set(pri_set),
        .sec_set(sec_set), .sec_use(sec_use), .fwd_set(fwd_set), .aux_in(aux_in),
        .pri_in(pri_in), .sec_in(sec_in), .secondary_input_enable(secondary_input_enable),
        .forward_start(forward_start));
    // ==========================================
    // access and check tasks
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] s, input logic [15:0] d);
        @(negedge clock);
        wr_en = 1'b1;
        wr_sel = s;
        wr_data = d;
        #5;
        a = wr_ack;
        e = wr_err;
        @(negedge clock);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [4:0] s);
        @(negedge clock);
        wr_sel = s;
        #5;
        v = setting_rd;
    endtask
    // filter setting 0 gives the quickest tick, one step lands in about 15625 cycles
    task automatic run(input logic [15:0] code, input logic [11:0] aux, input logic [11:0] pri,
        input logic su, input logic fw);
        @(negedge clock);
        srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        aux_set = aux;
        pri_set = pri;
        sec_set = 12'h3e8;
        sec_use = su;
        fwd_set = fw;
        wr(5'h00, code);
        wr(5'h05, 16'h0000);
        wr(5'h0e, 16'h0000);
    endtask
    task automatic wait_for(input bit want_rev);
        int i;
        for (i = 0; i < 20000; i++) begin
            @(negedge clock);
            if ((want_rev ? reverse_cmd : |freq_cmd) === 1'b1) break;
        end
        if (i == 20000) begin
            chk("wait_done", 16'h0001, 16'h0000);
            conclude();
        end
    endtask
    // ==========================================
    // tests
    initial begin
        repeat (2) @(negedge clock);
        srst = 1'b0;
        for (int k = 0; k < 16; k++) begin
            rd(k[4:0]);
            chk("reset_value", RST_TAB[k], v);
        end
        chk("reset_flags", 16'h0000, {14'h0000, primary_current_mode, primary_10v_range});
        $display("test reset_values done");
        for (int k = 0; k < 16; k++) begin
            wr(k[4:0], MAX_TAB[k]);
            chk("ack_max", 16'h0001, {15'h0000, a});
            wr(k[4:0], MAX_TAB[k] + 16'h0001);
            chk("err_over", 16'h0001, {15'h0000, e});
            rd(k[4:0]);
            chk("kept_max", MAX_TAB[k], v);
        end
        $display("test ranges done");
        for (int c = 0; c < 18; c++) begin
            wr(5'h00, c[15:0]);
            chk("code_ack", {15'h0000, c != 8 && c != 9}, {15'h0000, a});
            cur = c inside {6, 7, 16, 17};
            ten = c inside {0, 2, 4, 10, 12, 14};
            repeat (3) @(negedge clock);
            if (a === 1'b1) begin
                chk("code_flags", {14'h0000, cur, ten},
                    {14'h0000, primary_current_mode, primary_10v_range});
            end
        end
        $display("test codes done");
        user_group_read_select = 5'h01;
        wr(5'h01, 16'h0064);
        chk("gated_err", 16'h0001, {15'h0000, e});
        rd(5'h01);
        chk("gated_kept", 16'h03e8, v);
        wr(5'h07, 16'h0000);
        chk("unit_ack", 16'h0001, {15'h0000, a});
        chk("unit_out", 16'h0000, {15'h0000, display_unit_select});
        user_group_read_select = 5'h00;
        $display("test write_gate done");
        run(16'h0000, 12'hc18, 12'h000, 1'b0, 1'b1);
        repeat (17000) @(negedge clock);
        chk("clamp_freq", 16'h0000, freq_cmd);
        chk("clamp_rev", 16'h0000, {15'h0000, reverse_cmd});
        $display("test clamp done");
        run(16'h0005, 12'h000, 12'h3e8, 1'b0, 1'b0);
        repeat (17000) @(negedge clock);
        chk("override_no_main", 16'h0000, freq_cmd);
        $display("test override done");
        run(16'h000a, 12'hc18, 12'h000, 1'b0, 1'b1);
        wait_for(1'b1);
        chk("reverse_freq", 16'h0001, {15'h0000, freq_cmd != 16'h0000});
        $display("test reverse done");
        run(16'h0001, 12'h000, 12'h3e8, 1'b0, 1'b0);
        wait_for(1'b0);
        chk("primary_span", 16'h0001, {15'h0000, freq_cmd <= 16'h1770});
        $display("test primary done");
        run(16'h0001, 12'h000, 12'h000, 1'b1, 1'b0);
        wait_for(1'b0);
        chk("secondary_span", 16'h0001, {15'h0000, freq_cmd <= 16'h1770});
        $display("test secondary done");
        conclude();
    end
endmodule
